// file: rtl/pll_ctrl_pkg.sv
// constants, field widths and state codes for the synthesizer bandwidth and lock control
// assumes a single 10 MHz system clock; reference and vco clocks arrive as sampled pins

package pll_ctrl_pkg;

  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int R_W   = 8;
  localparam int N_W   = 12;
  localparam int P_W   = 2;
  localparam int L_W   = 8;
  localparam int PER_W = 16;
  localparam int FB_W  = N_W + 3;

  // ****************************************************************
  // reset values and tolerances, in system clock cycles
  // ****************************************************************
  localparam logic [PER_W-1:0] ACQ_TOL_DEF  = 16'h0010;
  localparam logic [PER_W-1:0] LOCK_TOL_DEF = 16'h0004;
  localparam logic [PER_W-1:0] PER_MAX      = 16'hffff;
  localparam logic [PER_W-1:0] PER_ZERO     = 16'h0000;
  localparam logic             FLAG_RST     = 1'b0;

  // ****************************************************************
  // filter state
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_ACQ   = 3'b010,
    ST_TRACK = 3'b100
  } filt_state_e;

endpackage

// file: rtl/tick_if.sv
// one-cycle tick carried between the sampler, the dividers and the control
// assumes all parties sit on the same system clock
`timescale 1ns/10ps
`default_nettype none

interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

`default_nettype wire

// file: rtl/pin_sync.sv
// three-stage sampler for a clock arriving on a pin, giving a rising-edge tick
// assumes the pin toggles well below half the system clock rate
`timescale 1ns/10ps
`default_nettype none

module pin_sync
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  tick_if.src       rise_t
);

  // ****************************************************************
  // sampler
  // ****************************************************************
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic rise_reg;
  logic level_next;
  logic rise_next;

  // first stage feeds only the second; a change counts when stages two and three agree
  always_comb
  begin
    level_next = level_reg;
    rise_next  = 1'b0;
    if (s2_reg == s3_reg && s3_reg != level_reg)
    begin
      level_next = s3_reg;
      rise_next  = s3_reg;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
      rise_reg  <= 1'b0;
    end
    else
    begin
      s1_reg    <= pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
      rise_reg  <= rise_next;
    end
  end

  assign rise_t.tick = rise_reg;

  single_rise_a: assert property (@(posedge clk) disable iff (rst)
    rise_reg |=> !rise_reg) else $error("edge tick lasted two cycles");

endmodule

`default_nettype wire

// file: rtl/tick_divider.sv
// modulo divider of input ticks: one output tick per modulus input ticks
// assumes modulus is never zero; the caller maps zero to one
`timescale 1ns/10ps
`default_nettype none

module tick_divider
#(
  parameter int MOD_W = 8
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             en,
  input  wire logic [MOD_W-1:0] modulus,
  tick_if.dst                   in_t,
  tick_if.src                   out_t
);

  // ****************************************************************
  // counter
  // ****************************************************************
  logic [MOD_W-1:0] count_reg;
  logic [MOD_W-1:0] count_next;
  logic             out_reg;
  logic             out_next;

  always_comb
  begin
    count_next = count_reg;
    out_next   = 1'b0;
    if (!en)
      count_next = '0;
    else if (in_t.tick)
    begin
      if (count_reg >= modulus - MOD_W'(1))
      begin
        count_next = '0;
        out_next   = 1'b1;
      end
      else
        count_next = count_reg + MOD_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_reg <= '0;
      out_reg   <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      out_reg   <= out_next;
    end
  end

  assign out_t.tick = out_reg;

  div_wrap_a: assert property (@(posedge clk) disable iff (rst)
    out_reg |-> $past(en && in_t.tick && count_reg >= modulus - MOD_W'(1)))
    else $error("divider ticked before modulus reached");

endmodule

`default_nettype wire

// file: rtl/pll_bw_lock_ctrl.sv
// bandwidth selection, lock detection and lock-change interrupt for the synthesizer
// assumes reference and vco clocks come in on pins, slower than half of clk;
// the analog vco, loop filter and clock transition circuit sit outside
`timescale 1ns/10ps
`default_nettype none

module pll_bw_lock_ctrl
#(
  parameter logic [pll_ctrl_pkg::PER_W-1:0] ACQ_TOL  = pll_ctrl_pkg::ACQ_TOL_DEF,
  parameter logic [pll_ctrl_pkg::PER_W-1:0] LOCK_TOL = pll_ctrl_pkg::LOCK_TOL_DEF
)
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ref_clk_pin,
  input  wire logic                          vco_clk_pin,
  input  wire logic                          auto_mode,
  input  wire logic                          synth_power_on,
  input  wire logic                          manual_filter_mode,
  input  wire logic [pll_ctrl_pkg::R_W-1:0]  ref_div_r,
  input  wire logic [pll_ctrl_pkg::N_W-1:0]  mult_n,
  input  wire logic [pll_ctrl_pkg::P_W-1:0]  prescale_p,
  input  wire logic [pll_ctrl_pkg::L_W-1:0]  range_l,
  input  wire logic                          base_clock_select_req,
  input  wire logic                          lock_change_irq_enable,
  input  wire logic                          irq_ack,
  output logic                               pll_enable,
  output logic                               base_clock_select,
  output logic                               filter_mode_flag,
  output logic                               filter_tracking,
  output logic                               freq_settled_flag,
  output logic                               lock_change_irq,
  output logic                               divided_reference_clock,
  output logic                               divided_feedback_clock
);

  // ****************************************************************
  // pin sampling and dividers
  // ****************************************************************
  tick_if ref_raw ();
  tick_if vco_raw ();
  tick_if ref_div ();
  tick_if fb_div ();

  logic [pll_ctrl_pkg::R_W-1:0]  r_eff;
  logic [pll_ctrl_pkg::N_W-1:0]  n_eff;
  logic [pll_ctrl_pkg::FB_W-1:0] fb_mod;
  logic                          pll_en_c;

  assign r_eff    = (ref_div_r == '0) ? pll_ctrl_pkg::R_W'(1) : ref_div_r;
  assign n_eff    = (mult_n == '0) ? pll_ctrl_pkg::N_W'(1) : mult_n;
  // feedback modulus is n scaled by two to the p, so vco = ref * 2^p * n / r
  assign fb_mod   = pll_ctrl_pkg::FB_W'(n_eff) << prescale_p;
  assign pll_en_c = synth_power_on && (range_l != '0);

  pin_sync u_ref_sync
  (
    .clk    (clk),
    .rst    (rst),
    .pin    (ref_clk_pin),
    .rise_t (ref_raw)
  );

  pin_sync u_vco_sync
  (
    .clk    (clk),
    .rst    (rst),
    .pin    (vco_clk_pin),
    .rise_t (vco_raw)
  );

  tick_divider #(.MOD_W(pll_ctrl_pkg::R_W)) u_ref_div
  (
    .clk     (clk),
    .rst     (rst),
    .en      (pll_en_c),
    .modulus (r_eff),
    .in_t    (ref_raw),
    .out_t   (ref_div)
  );

  tick_divider #(.MOD_W(pll_ctrl_pkg::FB_W)) u_fb_div
  (
    .clk     (clk),
    .rst     (rst),
    .en      (pll_en_c),
    .modulus (fb_mod),
    .in_t    (vco_raw),
    .out_t   (fb_div)
  );

  // ****************************************************************
  // period measurement
  // ****************************************************************
  // periods are counted in clk cycles; resolution limits how tight the tolerances may be
  logic [pll_ctrl_pkg::PER_W-1:0] ref_cnt_reg;
  logic [pll_ctrl_pkg::PER_W-1:0] ref_cnt_next;
  logic [pll_ctrl_pkg::PER_W-1:0] fb_cnt_reg;
  logic [pll_ctrl_pkg::PER_W-1:0] fb_cnt_next;
  logic [pll_ctrl_pkg::PER_W-1:0] fb_per_reg;
  logic [pll_ctrl_pkg::PER_W-1:0] fb_per_next;
  logic                           fb_valid_reg;
  logic                           fb_valid_next;
  logic [pll_ctrl_pkg::PER_W-1:0] fb_eff;
  logic [pll_ctrl_pkg::PER_W-1:0] diff;
  logic                           within_acq;
  logic                           within_lock;

  always_comb
  begin
    ref_cnt_next  = (ref_cnt_reg == pll_ctrl_pkg::PER_MAX) ? ref_cnt_reg
                    : ref_cnt_reg + pll_ctrl_pkg::PER_W'(1);
    fb_cnt_next   = (fb_cnt_reg == pll_ctrl_pkg::PER_MAX) ? fb_cnt_reg
                    : fb_cnt_reg + pll_ctrl_pkg::PER_W'(1);
    fb_per_next   = fb_per_reg;
    fb_valid_next = fb_valid_reg;
    if (!pll_en_c)
    begin
      ref_cnt_next  = pll_ctrl_pkg::PER_ZERO;
      fb_cnt_next   = pll_ctrl_pkg::PER_ZERO;
      fb_valid_next = 1'b0;
    end
    else
    begin
      if (ref_div.tick)
        ref_cnt_next = pll_ctrl_pkg::PER_ZERO;
      if (fb_div.tick)
      begin
        fb_per_next   = fb_cnt_reg;
        fb_cnt_next   = pll_ctrl_pkg::PER_ZERO;
        fb_valid_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ref_cnt_reg  <= pll_ctrl_pkg::PER_ZERO;
      fb_cnt_reg   <= pll_ctrl_pkg::PER_ZERO;
      fb_per_reg   <= pll_ctrl_pkg::PER_ZERO;
      fb_valid_reg <= 1'b0;
    end
    else
    begin
      ref_cnt_reg  <= ref_cnt_next;
      fb_cnt_reg   <= fb_cnt_next;
      fb_per_reg   <= fb_per_next;
      fb_valid_reg <= fb_valid_next;
    end
  end

  // a stalled vco shows as a growing open period, so it still fails the compare
  always_comb
  begin
    fb_eff      = (fb_cnt_reg > fb_per_reg) ? fb_cnt_reg : fb_per_reg;
    diff        = (ref_cnt_reg > fb_eff) ? ref_cnt_reg - fb_eff : fb_eff - ref_cnt_reg;
    within_acq  = fb_valid_reg && (diff <= ACQ_TOL);
    within_lock = fb_valid_reg && (diff <= LOCK_TOL);
  end

  // ****************************************************************
  // filter state, flags and interrupt
  // ****************************************************************
  pll_ctrl_pkg::filt_state_e state_reg;
  pll_ctrl_pkg::filt_state_e state_next;
  logic                      flag_next;
  logic                      track_next;
  logic                      lock_next;
  logic                      irq_next;
  logic                      bcs_next;

  always_comb
  begin
    case (state_reg)
      pll_ctrl_pkg::ST_OFF:
        state_next = pll_en_c ? pll_ctrl_pkg::ST_ACQ : pll_ctrl_pkg::ST_OFF;
      pll_ctrl_pkg::ST_ACQ:
        if (!pll_en_c)
          state_next = pll_ctrl_pkg::ST_OFF;
        else if (ref_div.tick && within_acq)
          state_next = pll_ctrl_pkg::ST_TRACK;
        else
          state_next = pll_ctrl_pkg::ST_ACQ;
      pll_ctrl_pkg::ST_TRACK:
        if (!pll_en_c)
          state_next = pll_ctrl_pkg::ST_OFF;
        else if (ref_div.tick && !within_acq)
          state_next = pll_ctrl_pkg::ST_ACQ;
        else
          state_next = pll_ctrl_pkg::ST_TRACK;
      default:
        state_next = pll_ctrl_pkg::ST_OFF;
    endcase
  end

  always_comb
  begin
    if (auto_mode)
    begin
      flag_next  = (state_next == pll_ctrl_pkg::ST_TRACK);
      track_next = (state_next != pll_ctrl_pkg::ST_ACQ);
    end
    else
    begin
      flag_next  = manual_filter_mode;
      track_next = manual_filter_mode;
    end
    if (!auto_mode || !pll_en_c)
      lock_next = 1'b0;
    else if (ref_div.tick)
      lock_next = within_lock;
    else
      lock_next = freq_settled_flag;
    // set wins over acknowledge in the same cycle
    if (!lock_change_irq_enable || !auto_mode)
      irq_next = 1'b0;
    else if (lock_next != freq_settled_flag)
      irq_next = 1'b1;
    else if (irq_ack)
      irq_next = 1'b0;
    else
      irq_next = lock_change_irq;
    bcs_next = base_clock_select_req && pll_en_c;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg         <= pll_ctrl_pkg::ST_OFF;
      filter_mode_flag  <= pll_ctrl_pkg::FLAG_RST;
      filter_tracking   <= pll_ctrl_pkg::FLAG_RST;
      freq_settled_flag <= pll_ctrl_pkg::FLAG_RST;
      lock_change_irq   <= pll_ctrl_pkg::FLAG_RST;
      base_clock_select <= pll_ctrl_pkg::FLAG_RST;
      pll_enable        <= pll_ctrl_pkg::FLAG_RST;
    end
    else
    begin
      state_reg         <= state_next;
      filter_mode_flag  <= flag_next;
      filter_tracking   <= track_next;
      freq_settled_flag <= lock_next;
      lock_change_irq   <= irq_next;
      base_clock_select <= bcs_next;
      pll_enable        <= pll_en_c;
    end
  end

  assign divided_reference_clock = ref_div.tick;
  assign divided_feedback_clock  = fb_div.tick;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  acq_flag_zero_a: assert property ($past(auto_mode) && state_reg == pll_ctrl_pkg::ST_ACQ
    |-> !filter_mode_flag) else $error("flag set while acquiring");
  flag_tracks_a: assert property (filter_mode_flag |-> filter_tracking)
    else $error("flag set but not tracking");
  auto_flag_state_a: assert property ($past(auto_mode)
    |-> filter_mode_flag == (state_reg == pll_ctrl_pkg::ST_TRACK))
    else $error("auto flag differs from state");
  settle_rise_a: assert property ($rose(freq_settled_flag)
    |-> $past(ref_div.tick && within_lock && auto_mode))
    else $error("settled without a passing compare");
  irq_on_toggle_a: assert property ($changed(freq_settled_flag)
    && $past(auto_mode && lock_change_irq_enable) |-> lock_change_irq)
    else $error("toggle without interrupt");
  manual_write_a: assert property ($past(!auto_mode)
    |-> filter_mode_flag == $past(manual_filter_mode))
    else $error("manual flag not followed");
  manual_quiet_a: assert property (!auto_mode |=> !freq_settled_flag && !lock_change_irq)
    else $error("manual mode shows lock or interrupt");
  irq_hold_a: assert property (lock_change_irq && auto_mode && lock_change_irq_enable
    && !irq_ack |=> lock_change_irq) else $error("interrupt dropped unserviced");
  vco_select_gate_a: assert property (base_clock_select
    |-> $past(synth_power_on && range_l != '0)) else $error("vco selected while off");

endmodule

`default_nettype wire

// file: tb/tb_pll_bandwidth_lock_control.sv
// self-checking bench for the synthesizer bandwidth, lock and base clock control
// assumes one 10 MHz clock; the bench makes the reference and vco pins itself
`timescale 1ns/10ps
`default_nettype none

module tb_pll_bandwidth_lock_control;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic                         clk;
  logic                         rst;
  logic                         ref_clk_pin;
  logic                         vco_clk_pin;
  logic                         auto_mode;
  logic                         synth_power_on;
  logic                         manual_filter_mode;
  logic [pll_ctrl_pkg::R_W-1:0] ref_div_r;
  logic [pll_ctrl_pkg::N_W-1:0] mult_n;
  logic [pll_ctrl_pkg::P_W-1:0] prescale_p;
  logic [pll_ctrl_pkg::L_W-1:0] range_l;
  logic                         base_clock_select_req;
  logic                         lock_change_irq_enable;
  logic                         irq_ack;
  logic                         pll_enable;
  logic                         base_clock_select;
  logic                         filter_mode_flag;
  logic                         filter_tracking;
  logic                         freq_settled_flag;
  logic                         lock_change_irq;
  logic                         divided_reference_clock;
  logic                         divided_feedback_clock;
  int                           ref_half;
  int                           vco_half;
  int                           ref_cnt;
  int                           vco_cnt;
  int                           err_total;
  int                           samples_checked;
  logic [15:0]                  gap;

  // bench stand-ins for the manual-mode settling waits, in clk cycles
  localparam int acquisition_wait_time = 20;
  localparam int lock_wait_time        = 20;

  pll_bw_lock_ctrl dut
  (
    .clk                    (clk),
    .rst                    (rst),
    .ref_clk_pin            (ref_clk_pin),
    .vco_clk_pin            (vco_clk_pin),
    .auto_mode              (auto_mode),
    .synth_power_on         (synth_power_on),
    .manual_filter_mode     (manual_filter_mode),
    .ref_div_r              (ref_div_r),
    .mult_n                 (mult_n),
    .prescale_p             (prescale_p),
    .range_l                (range_l),
    .base_clock_select_req  (base_clock_select_req),
    .lock_change_irq_enable (lock_change_irq_enable),
    .irq_ack                (irq_ack),
    .pll_enable             (pll_enable),
    .base_clock_select      (base_clock_select),
    .filter_mode_flag       (filter_mode_flag),
    .filter_tracking        (filter_tracking),
    .freq_settled_flag      (freq_settled_flag),
    .lock_change_irq        (lock_change_irq),
    .divided_reference_clock(divided_reference_clock),
    .divided_feedback_clock (divided_feedback_clock)
  );

  // ****************************************************************
  // clock and pin generators
  // ****************************************************************
  always #50 clk = ~clk;

  // a half period of 0 parks the pin, which starves the detector
  always @(negedge clk)
  begin
    if (ref_half != 0)
    begin
      ref_cnt <= (ref_cnt >= ref_half - 1) ? 0 : ref_cnt + 1;
      if (ref_cnt >= ref_half - 1)
        ref_clk_pin <= ~ref_clk_pin;
    end
    if (vco_half != 0)
    begin
      vco_cnt <= (vco_cnt >= vco_half - 1) ? 0 : vco_cnt + 1;
      if (vco_cnt >= vco_half - 1)
        vco_clk_pin <= ~vco_clk_pin;
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // cycles between two ticks of the chosen divided clock, bounded
  task automatic tick_gap(input logic fb, output logic [15:0] g);
    int i;
    g = 16'hffff;
    i = 0;
    while (((fb ? divided_feedback_clock : divided_reference_clock) !== 1'b1) && i < 2000)
    begin
      cyc(1);
      i++;
    end
    for (int k = 1; k < 2000; k++)
    begin
      cyc(1);
      if ((fb ? divided_feedback_clock : divided_reference_clock) === 1'b1)
      begin
        g = k[15:0];
        break;
      end
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    check("settled in reset", freq_settled_flag, 1'b0);
    check("irq in reset", lock_change_irq, 1'b0);
    check("select in reset", base_clock_select, 1'b0);
    check("flag in reset", filter_mode_flag, 1'b0);
  endtask

  // manual bring-up in the order software must keep
  task automatic t_select();
    manual_filter_mode = 1'b0;
    range_l = 8'h01;
    synth_power_on = 1'b1;
    cyc(acquisition_wait_time);
    manual_filter_mode = 1'b1;
    cyc(lock_wait_time);
    base_clock_select_req = 1'b1;
    cyc(2);
    check("select with l one", base_clock_select, 1'b1);
    check("enable with l one", pll_enable, 1'b1);
    range_l = 8'h00;
    cyc(2);
    check("select with l zero", base_clock_select, 1'b0);
    check("enable with l zero", pll_enable, 1'b0);
    range_l = 8'h01;
    synth_power_on = 1'b0;
    cyc(2);
    check("select power off", base_clock_select, 1'b0);
    base_clock_select_req = 1'b0;
    manual_filter_mode = 1'b0;
    cyc(1);
    synth_power_on = 1'b1;
  endtask

  task automatic t_dividers();
    ref_half = 4;
    vco_half = 4;
    ref_div_r = 8'h00;
    mult_n = 12'h000;
    cyc(40);
    tick_gap(1'b0, gap);
    check("ref gap r zero", gap, 16'h0008);
    tick_gap(1'b1, gap);
    check("fb gap n zero", gap, 16'h0008);
    ref_div_r = 8'h03;
    mult_n = 12'h003;
    // prescale exponent goes to one here; nothing in the bench ever drives it to three
    prescale_p = 2'h1;
    cyc(200);
    tick_gap(1'b0, gap);
    check("ref gap r three", gap, 16'h0018);
    tick_gap(1'b1, gap);
    check("fb gap n three p one", gap, 16'h0030);
  endtask

  task automatic wait_flag(input logic want_settled, input logic want);
    int i;
    for (i = 0; i < 3000; i++)
    begin
      if ((want_settled ? freq_settled_flag : filter_mode_flag) === want)
        break;
      cyc(1);
    end
  endtask

  task automatic t_auto_lock();
    // reference period 40, feedback period 8*5 = 40: equal periods
    auto_mode = 1'b1;
    lock_change_irq_enable = 1'b1;
    ref_div_r = 8'h01;
    mult_n = 12'h005;
    prescale_p = 2'h0;
    ref_half = 20;
    vco_half = 4;
    // let periods left over from the divider test wash out first
    cyc(400);
    wait_flag(1'b1, 1'b1);
    check("settled on match", freq_settled_flag, 1'b1);
    check("irq on lock", lock_change_irq, 1'b1);
    base_clock_select_req = 1'b1;
    cyc(1);
    check("select once settled", base_clock_select, 1'b1);
    check("flag on match", filter_mode_flag, 1'b1);
    check("tracking on match", filter_tracking, 1'b1);
    cyc(5);
    check("irq held", lock_change_irq, 1'b1);
    irq_ack = 1'b1;
    cyc(1);
    irq_ack = 1'b0;
    cyc(1);
    check("irq after ack", lock_change_irq, 1'b0);
    // feedback period 30: off by 10, past lock but inside acquisition tolerance
    vco_half = 3;
    wait_flag(1'b1, 1'b0);
    check("settled lost", freq_settled_flag, 1'b0);
    check("irq on unlock", lock_change_irq, 1'b1);
    check("still tracking", filter_tracking, 1'b1);
    base_clock_select_req = 1'b0;
    lock_change_irq_enable = 1'b0;
    cyc(2);
    check("irq enable off", lock_change_irq, 1'b0);
    check("select dropped", base_clock_select, 1'b0);
    vco_half = 0;
    wait_flag(1'b0, 1'b0);
    check("flag in acquisition", filter_mode_flag, 1'b0);
    check("acquiring", filter_tracking, 1'b0);
  endtask

  task automatic t_manual();
    vco_half = 4;
    lock_change_irq_enable = 1'b1;
    auto_mode = 1'b0;
    manual_filter_mode = 1'b1;
    cyc(2);
    check("manual flag set", filter_mode_flag, 1'b1);
    check("manual tracking", filter_tracking, 1'b1);
    cyc(400);
    check("manual settled off", freq_settled_flag, 1'b0);
    check("manual irq off", lock_change_irq, 1'b0);
    manual_filter_mode = 1'b0;
    cyc(2);
    check("manual flag clear", filter_mode_flag, 1'b0);
    check("manual acquiring", filter_tracking, 1'b0);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ref_clk_pin = 1'b0;
    vco_clk_pin = 1'b0;
    auto_mode = 1'b0;
    synth_power_on = 1'b0;
    manual_filter_mode = 1'b0;
    ref_div_r = 8'h01;
    mult_n = 12'h001;
    prescale_p = 2'h0;
    range_l = 8'h00;
    base_clock_select_req = 1'b0;
    lock_change_irq_enable = 1'b0;
    irq_ack = 1'b0;
    ref_half = 0;
    vco_half = 0;
    ref_cnt = 0;
    vco_cnt = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (12) @(negedge clk);
    t_reset();
    rst = 1'b0;
    cyc(2);
    t_select();
    t_dividers();
    t_auto_lock();
    t_manual();
    finish_test();
  end

  // whole run needs well under 20000 cycles
  initial
  begin
    #4000000;
    err_total++;
    finish_test();
  end
endmodule

`default_nettype wire
